/* File: dv/rssa_alu_tb.sv */
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes rssa_core_model stands in for data memory and fetch.
`timescale 1ns/1ps
`default_nettype none

module rssa_alu_tb;
    import rssa_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    // Expected outcome of one operation.
    typedef struct packed {
        logic        sk;
        logic        we;
        logic [7:0]  wd;
        logic [7:0]  wk;
        rssa_flags_t fl;
    } rssa_exp_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    rssa_req_t   rq = '0;
    logic        ld = 1'b0;
    logic [7:0]  ld_val = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        op_ready_q, mem_we_q, discard_q, pready, pslverr;
    logic [7:0]  mem_wdata_q, work_q, mem_q;
    logic [31:0] prdata;
    rssa_flags_t flags_q;
    int          n_discard, n_mismatch = 0, n_tests = 0, cycles = 0;
    // Operand sets; they include a signed overflow and a zero wrap.
    logic [7:0]  a_w [3] = '{8'h80, 8'h05, 8'h3C};
    logic [7:0]  a_m [3] = '{8'h01, 8'hFF, 8'h6A};
    logic [7:0]  a_x [3] = '{8'h01, 8'h05, 8'hC3};
    logic [3:0]  a_f [3] = '{4'h1, 4'hE, 4'h0};
    logic [2:0]  a_b [3] = '{3'h0, 3'h7, 3'h4};

    // The clock flips every half period of 25 ns.
    always #25 clk = ~clk;

    rssa_alu uut (
        .clk(clk), .rst(rst), .req_i({rq.valid, rq.op, mem_q, rq.imm, rq.bsel}),
        .op_ready_q(op_ready_q), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
        .discard_q(discard_q), .work_q(work_q), .flags_q(flags_q),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    rssa_core_model model (
        .clk(clk), .rst(rst), .ld(ld), .ld_val(ld_val), .mem_we_q(mem_we_q),
        .mem_wdata_q(mem_wdata_q), .discard_q(discard_q), .mem_q(mem_q),
        .n_discard(n_discard)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // A hang would stall the run, so a generous cycle ceiling cuts it.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int   n = 0;
        logic rdy;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is sampled mid-cycle, so it is the value the next edge sees.
        do begin
            @(negedge clk);
            rdy = pready;
            rd = prdata;
            er = pslverr;
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Loads the working register, flags and memory byte before an operation.
    task automatic set_state(input logic [7:0] w, m, input logic [3:0] f);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, RSSA_OFS_WORK, 32'(w), rd, er);
        apb(1'b1, RSSA_OFS_FLAGS, 32'(f), rd, er);
        ld <= 1'b1;
        ld_val <= m;
        @(posedge clk);
        ld <= 1'b0;
    endtask

    // Holds a request until it is taken; returns the edges that it waited.
    task automatic issue(input rssa_op_t o, input logic [7:0] x, input logic [2:0] b,
                         output int cyc);
        logic rdy;
        rq <= '{valid: 1'b1, op: o, mem: 8'h00, imm: x, bsel: b};
        cyc = 0;
        // Ready is read mid-cycle, so the edge that follows takes the request.
        do begin
            @(negedge clk);
            rdy = op_ready_q;
            @(posedge clk);
            cyc++;
        end while (rdy !== 1'b1 && cyc < 20);
        #1;
    endtask

    // Expected result worked out from operand values alone.
    function automatic rssa_exp_t gold(rssa_op_t o, logic [7:0] w, m, x, logic [2:0] b,
                                       rssa_flags_t f);
        rssa_exp_t  e;
        logic [7:0] y;
        logic [8:0] s;
        logic [4:0] h;
        logic       ci;
        e = '{sk: 1'b0, we: 1'b0, wd: 8'h00, wk: w, fl: f};
        y = (o == subtract_imm_to_work) ? x : m;
        ci = (o == subtract_with_borrow_to_work || o == subtract_with_borrow_to_mem) ? f.c : 1'b1;
        s = {1'b0, w} + {1'b0, ~y} + 9'(ci);
        h = {1'b0, w[3:0]} + {1'b0, ~y[3:0]} + 5'(ci);
        e.we = o inside {rotate_left_thru_carry_mem, rotate_right_mem, rotate_right_thru_carry_mem,
                         subtract_with_borrow_to_mem, subtract_to_mem, decrement_skip_zero_mem,
                         increment_skip_zero_mem, set_byte_mem, set_bit_mem, nibble_exchange_mem};
        case (o)
            rotate_left_thru_carry_mem, rotate_left_thru_carry_to_work: begin
                {e.fl.c, e.wd} = {m, f.c};
            end
            rotate_right_mem, rotate_right_to_work: e.wd = {m[0], m[7:1]};
            rotate_right_thru_carry_mem, rotate_right_thru_carry_to_work: begin
                {e.wd, e.fl.c} = {f.c, m};
            end
            decrement_skip_zero_mem, decrement_skip_zero_to_work: e.wd = m - 8'h01;
            increment_skip_zero_mem, increment_skip_zero_to_work: e.wd = m + 8'h01;
            skip_if_bit_one: e.sk = m[b];
            set_byte_mem: e.wd = 8'hFF;
            set_bit_mem: e.wd = m | (8'h01 << b);
            nibble_exchange_mem, nibble_exchange_to_work: e.wd = {m[3:0], m[7:4]};
            default: e.wd = s[7:0];
        endcase
        if (o >= decrement_skip_zero_mem && o <= increment_skip_zero_to_work) begin
            e.sk = (e.wd == 8'h00);
        end
        if (o >= subtract_with_borrow_to_work && o <= subtract_imm_to_work) begin
            e.fl = '{signed_overflow_flag: (w[7] != y[7]) && (s[7] != w[7]),
                     z: (s[7:0] == 8'h00),
                     half_carry_flag: h[4], c: s[8]};
        end
        // Operations that only move data to the working register.
        if (!e.we && o != skip_if_bit_one && o != op_none) begin
            e.wk = e.wd;
        end
        return e;
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, data width, a read-only place and an unmapped address.
    task automatic t_regs();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, RSSA_OFS_WORK, 32'h0000_0000, rd, er);
        chk("work reset", 32'h0000_0000, rd);
        apb(1'b0, RSSA_OFS_STATUS, 32'h0000_0000, rd, er);
        chk("status reset", 32'h0000_0005, rd);
        apb(1'b1, RSSA_OFS_WORK, 32'hFFFF_FFA5, rd, er);
        apb(1'b1, RSSA_OFS_FLAGS, 32'h0000_00FF, rd, er);
        apb(1'b1, RSSA_OFS_STATUS, 32'h0000_0000, rd, er);
        apb(1'b0, RSSA_OFS_WORK, 32'h0000_0000, rd, er);
        chk("work read", 32'h0000_00A5, rd);
        chk("mapped error", 32'h0000_0000, 32'(er));
        apb(1'b0, RSSA_OFS_FLAGS, 32'h0000_0000, rd, er);
        chk("flags read", 32'h0000_000F, {rd[31:4], 4'(flags_q)});
        apb(1'b0, RSSA_OFS_STATUS, 32'h0000_0000, rd, er);
        chk("status kept", 32'h0000_0005, rd);
        apb(1'b0, 8'h0C, 32'h0000_0000, rd, er);
        chk("unmapped", 32'h0000_0001, {rd[30:0], er});
        $display("test regs done");
    endtask

    // Every operation code against every operand set.
    task automatic t_ops();
        rssa_exp_t e;
        int        cyc;
        int        base = n_discard;
        int        nsk = 0;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i <= 20; i++) begin
                set_state(a_w[k], a_m[k], a_f[k]);
                e = gold(rssa_op_t'(i), a_w[k], a_m[k], a_x[k], a_b[k], a_f[k]);
                issue(rssa_op_t'(i), a_x[k], a_b[k], cyc);
                chk("work", 32'(e.wk), 32'(work_q));
                chk("flags", 32'(e.fl), 32'(flags_q));
                chk("write", 32'(e.we), 32'(mem_we_q));
                if (e.we) begin
                    chk("wdata", 32'(e.wd), 32'(mem_wdata_q));
                end
                chk("discard", 32'(e.sk), 32'(discard_q));
                chk("ready", 32'(!e.sk), 32'(op_ready_q));
                nsk += int'(e.sk);
                rq.valid <= 1'b0;
                @(posedge clk);
                #1;
                chk("memory", 32'(e.we ? e.wd : a_m[k]), 32'(mem_q));
            end
        end
        chk("discards", 32'(nsk), 32'(n_discard - base));
        $display("test ops done");
    endtask

    // Back-to-back requests: two cycles after a skip, one otherwise.
    task automatic t_cycles();
        int c;
        set_state(8'h00, 8'h01, 4'h0);
        issue(decrement_skip_zero_mem, 8'h00, 3'h0, c);
        issue(rotate_right_mem, 8'h00, 3'h0, c);
        chk("skip gap", 32'h0000_0002, 32'(c));
        issue(nibble_exchange_to_work, 8'h00, 3'h0, c);
        issue(set_byte_mem, 8'h00, 3'h0, c);
        chk("plain gap", 32'h0000_0001, 32'(c));
        rq.valid <= 1'b0;
        $display("test cycles done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_ops();
        t_cycles();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: dv/rssa_core_model.sv */
// Partner model: the data-memory byte that the datapath reads and writes,
// and the fetch side, which counts discarded prefetches. One clock assumed.
`timescale 1ns/1ps
`default_nettype none

module rssa_core_model (
    // Clock, reset and bench load port.
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ld,
    input  wire logic [7:0] ld_val,
    // Datapath outputs seen by memory and fetch.
    input  wire logic       mem_we_q,
    input  wire logic [7:0] mem_wdata_q,
    input  wire logic       discard_q,
    // Operand byte and discard count.
    output logic [7:0]      mem_q,
    output int              n_discard
);
    // ------------------------------------------------------------------
    // Memory byte
    // ------------------------------------------------------------------
    // Memory takes write data on every strobe; a bench load wins a tie.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q     <= 8'h00;
            n_discard <= 0;
        end else begin
            if (ld) begin
                mem_q <= ld_val;
            end else if (mem_we_q) begin
                mem_q <= mem_wdata_q;
            end
            n_discard <= n_discard + int'(discard_q);
        end
    end
endmodule
`default_nettype wire

/* File: src/rssa_alu.sv */
// Execution datapath for rotates, subtractions, set, swap and skip operations.
// Assumes the decoder holds a request until op_ready_q is seen high, and that
// data memory takes mem_wdata_q whenever mem_we_q is high.
`timescale 1ns/1ps
`default_nettype none

module rssa_alu (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Decoder request.
    input  wire rssa_pkg::rssa_req_t   req_i,
    output logic                       op_ready_q,
    // Results toward memory, fetch and the core.
    output logic                       mem_we_q,
    output logic [7:0]                 mem_wdata_q,
    output logic                       discard_q,
    output logic [7:0]                 work_q,
    output rssa_pkg::rssa_flags_t      flags_q,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);
    import rssa_pkg::*;

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    rssa_regs_t q;      // Registered state.
    rssa_regs_t d;      // Next state.
    logic       take;   // Request accepted at this edge.

    assign take = req_i.valid && q.ready;

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    // The APB write is applied first so that an operation finishing in the
    // same cycle overrides it; the core's own update must never be lost.
    always_comb begin
        logic [7:0] b;
        logic       cin;
        logic [8:0] s9;
        logic [4:0] s5;
        logic [7:0] res;
        logic       sk;
        b   = 8'h00;
        cin = 1'b0;
        s9  = 9'h000;
        s5  = 5'h00;
        res = 8'h00;
        sk  = 1'b0;
        d   = q;
        d.mem_we  = 1'b0;
        d.discard = 1'b0;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;

        // Bus setup cycle: prepare the answer for the access phase.
        if (psel && !penable) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            case (paddr)
                RSSA_OFS_WORK:   d.prdata[7:0] = q.work;
                RSSA_OFS_FLAGS:  d.prdata[3:0] = q.fl;
                RSSA_OFS_STATUS: d.prdata[3:0] = {q.skip_last, q.ready, q.st};
                default:         d.pslverr = 1'b1;
            endcase
        end
        // Access edge: commit a write to a writable register.
        if (psel && penable && q.pready && pwrite) begin
            if (paddr == RSSA_OFS_WORK) begin
                d.work = pwdata[7:0];
            end else if (paddr == RSSA_OFS_FLAGS) begin
                d.fl = pwdata[3:0];
            end
        end

        // Subtraction operand and carry in.
        case (req_i.op)
            subtract_with_borrow_to_work, subtract_with_borrow_to_mem: begin
                b   = ~req_i.mem;
                cin = q.fl.c;
            end
            subtract_imm_to_work: begin
                b   = ~req_i.imm;
                cin = 1'b1;
            end
            default: begin
                b   = ~req_i.mem;
                cin = 1'b1;
            end
        endcase
        s9 = {1'b0, q.work} + {1'b0, b} + {8'h00, cin};
        s5 = {1'b0, q.work[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

        // Sequencer: a taken skip spends one extra dummy cycle.
        case (q.st)
            st_exec: begin
                if (take) begin
                    case (req_i.op)
                        rotate_left_thru_carry_mem, rotate_left_thru_carry_to_work: begin
                            res = {req_i.mem[6:0], q.fl.c};
                            d.fl.c = req_i.mem[7];
                        end
                        rotate_right_mem, rotate_right_to_work: begin
                            res = {req_i.mem[0], req_i.mem[7:1]};
                        end
                        rotate_right_thru_carry_mem, rotate_right_thru_carry_to_work: begin
                            res = {q.fl.c, req_i.mem[7:1]};
                            d.fl.c = req_i.mem[0];
                        end
                        subtract_with_borrow_to_work, subtract_with_borrow_to_mem,
                        subtract_mem_to_work, subtract_to_mem, subtract_imm_to_work: begin
                            res     = s9[7:0];
                            d.fl.c  = s9[8];
                            d.fl.half_carry_flag      = s5[4];
                            d.fl.signed_overflow_flag = (q.work[7] == b[7])
                                                        && (s9[7] != q.work[7]);
                            d.fl.z  = (s9[7:0] == 8'h00);
                        end
                        decrement_skip_zero_mem, decrement_skip_zero_to_work: begin
                            res = req_i.mem - 8'h01;
                            sk  = (res == 8'h00);
                        end
                        increment_skip_zero_mem, increment_skip_zero_to_work: begin
                            res = req_i.mem + 8'h01;
                            sk  = (res == 8'h00);
                        end
                        skip_if_bit_one: begin
                            sk = req_i.mem[req_i.bsel];
                        end
                        set_byte_mem: begin
                            res = 8'hFF;
                        end
                        set_bit_mem: begin
                            res = req_i.mem | (8'h01 << req_i.bsel);
                        end
                        nibble_exchange_mem, nibble_exchange_to_work: begin
                            res = {req_i.mem[3:0], req_i.mem[7:4]};
                        end
                        default: begin
                            res = 8'h00;
                        end
                    endcase
                    // Route the result to its destination.
                    case (req_i.op)
                        rotate_left_thru_carry_mem, rotate_right_mem,
                        rotate_right_thru_carry_mem, subtract_with_borrow_to_mem,
                        subtract_to_mem, decrement_skip_zero_mem,
                        increment_skip_zero_mem, set_byte_mem, set_bit_mem,
                        nibble_exchange_mem: begin
                            d.mem_we = 1'b1;
                            d.mem_wd = res;
                        end
                        op_none, skip_if_bit_one: begin
                            d.mem_we = 1'b0;
                        end
                        default: begin
                            d.work = res;
                        end
                    endcase
                    d.skip_last = sk;
                    if (sk) begin
                        d.discard = 1'b1;
                        d.st      = st_dummy;
                    end
                end
            end
            st_dummy: begin
                d.st = st_exec;
            end
            default: begin
                d.st = st_exec;
            end
        endcase
        // No new request is accepted during the dummy cycle.
        d.ready = (d.st == st_exec);
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q           <= '0;
            q.st        <= st_exec;
            q.work      <= RSSA_WORK_RST;
            q.fl        <= RSSA_FLAGS_RST;
            q.ready     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign op_ready_q  = q.ready;
    assign mem_we_q    = q.mem_we;
    assign mem_wdata_q = q.mem_wd;
    assign discard_q   = q.discard;
    assign work_q      = q.work;
    assign flags_q     = q.fl;
    assign prdata      = q.prdata;
    assign pready      = q.pready;
    assign pslverr     = q.pslverr;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    skip_two_cyc_a: assert property (discard_q |-> !op_ready_q ##1 op_ready_q)
        else $error("skip did not take exactly one dummy cycle");
    rot_left_mem_a: assert property (take && req_i.op == rotate_left_thru_carry_mem
        |=> mem_we_q && mem_wdata_q == {$past(req_i.mem[6:0]), $past(flags_q.c)}
            && flags_q.c == $past(req_i.mem[7]))
        else $error("rotate left through carry wrong");
    ror_work_a: assert property (take && req_i.op == rotate_right_to_work
        |=> !mem_we_q && work_q == {$past(req_i.mem[0]), $past(req_i.mem[7:1])}
            && $stable(flags_q))
        else $error("rotate right to work wrong");
    rrc_mem_a: assert property (take && req_i.op == rotate_right_thru_carry_mem
        |=> mem_wdata_q == {$past(flags_q.c), $past(req_i.mem[7:1])}
            && flags_q.c == $past(req_i.mem[0]))
        else $error("rotate right through carry wrong");
    sub_carry_a: assert property (take && req_i.op == subtract_mem_to_work
        |=> flags_q.c == ($past(work_q) >= $past(req_i.mem)))
        else $error("subtract carry is not no-borrow");
    sbc_zero_a: assert property (take && req_i.op == subtract_with_borrow_to_mem
        |=> mem_we_q && flags_q.z == (mem_wdata_q == 8'h00))
        else $error("zero flag disagrees with result");
    dec_skip_a: assert property (take && req_i.op == decrement_skip_zero_mem
        |=> discard_q == ($past(req_i.mem) == 8'h01) && $stable(flags_q))
        else $error("decrement skip wrong");
    bit_skip_a: assert property (take && req_i.op == skip_if_bit_one
        |=> !mem_we_q && discard_q == $past(req_i.mem[req_i.bsel]))
        else $error("bit skip wrong");
    set_byte_a: assert property (take && req_i.op == set_byte_mem
        |=> mem_we_q && mem_wdata_q == 8'hFF && $stable(flags_q))
        else $error("set byte wrong");
    swap_work_a: assert property (take && req_i.op == nibble_exchange_to_work
        |=> !mem_we_q && work_q == {$past(req_i.mem[3:0]), $past(req_i.mem[7:4])})
        else $error("nibble exchange wrong");

endmodule

`default_nettype wire

/* File: src/rssa_pkg.sv */
// Shared types and constants of the rotate, subtract and skip datapath.
// Assumes one system clock and a decoder that presents one operation at a time.
// -----------------------------------------------------------------------------
// Behaviour
// - Rotate left through carry, result to memory.
// - Same rotate, result to working register only.
// - Rotate right wraps bit zero, to memory.
// - Rotate right to working register, flags kept.
// - Rotate right through carry, result to memory.
// - Same rotate, result to working register only.
// - Work plus inverted operand plus carry, flags updated.
// - Work plus inverted operand plus one, flags updated.
// - Immediate subtract into working register, flags updated.
// - Decrement, skip when zero, no flag change.
// - Increment, skip when zero, no flag change.
// - Taken skip discards prefetch: two cycles, else one.
// - Skip when selected memory bit is one.
// - Set byte writes all ones, flags kept.
// - Set bit forces one bit high only.
// - Nibble exchange to memory or working register.
// -----------------------------------------------------------------------------
package rssa_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] RSSA_OFS_WORK   = 8'h00;
    localparam logic [7:0] RSSA_OFS_FLAGS  = 8'h04;
    localparam logic [7:0] RSSA_OFS_STATUS = 8'h08;

    // Reset values.
    localparam logic [7:0] RSSA_WORK_RST  = 8'h00;
    localparam logic [3:0] RSSA_FLAGS_RST = 4'h0;

    // Cycles per instruction with and without a skip.
    localparam int RSSA_SKIP_CYCLES  = 2;
    localparam int RSSA_PLAIN_CYCLES = 1;

    // Flag word; carry sits in bit 0 of the flag register.
    typedef struct packed {
        logic signed_overflow_flag;  // Signed overflow.
        logic z;                     // Zero.
        logic half_carry_flag;       // Half carry out of the low nibble.
        logic c;    // Carry; set when a subtraction does not borrow.
    } rssa_flags_t;

    // Operations handled by this datapath.
    typedef enum logic [4:0] {
        op_none                         = 5'h00,
        rotate_left_thru_carry_mem      = 5'h01,
        rotate_left_thru_carry_to_work  = 5'h02,
        rotate_right_mem                = 5'h03,
        rotate_right_to_work            = 5'h04,
        rotate_right_thru_carry_mem     = 5'h05,
        rotate_right_thru_carry_to_work = 5'h06,
        subtract_with_borrow_to_work    = 5'h07,
        subtract_with_borrow_to_mem     = 5'h08,
        subtract_mem_to_work            = 5'h09,
        subtract_to_mem                 = 5'h0A,
        subtract_imm_to_work            = 5'h0B,
        decrement_skip_zero_mem         = 5'h0C,
        decrement_skip_zero_to_work     = 5'h0D,
        increment_skip_zero_mem         = 5'h0E,
        increment_skip_zero_to_work     = 5'h0F,
        skip_if_bit_one                 = 5'h10,
        set_byte_mem                    = 5'h11,
        set_bit_mem                     = 5'h12,
        nibble_exchange_mem             = 5'h13,
        nibble_exchange_to_work         = 5'h14
    } rssa_op_t;

    // One request from the decoder.
    typedef struct packed {
        logic       valid;  // Request present.
        rssa_op_t   op;     // Operation.
        logic [7:0] mem;    // Data-memory operand.
        logic [7:0] imm;    // Immediate operand.
        logic [2:0] bsel;   // Bit select.
    } rssa_req_t;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        st_exec  = 2'h1,
        st_dummy = 2'h2
    } rssa_state_t;

    // All state of the datapath.
    typedef struct packed {
        rssa_state_t st;
        logic [7:0]  work;
        rssa_flags_t fl;
        logic        mem_we;
        logic [7:0]  mem_wd;
        logic        discard;
        logic        ready;
        logic        skip_last;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } rssa_regs_t;

endpackage
